// [logic/fcc_fan_control_regs.sv]
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
// Function
// R1: Speed nibble is normal speed outside auto.
// R2: In auto, nibble is minimum fan speed.
// R3: Speed nibble resets to 0x05.
// R4: Spin-up disable bit skips spin-up.
// R5: Bits 6:5 select ramp step 1,2,4,8.
// R6: Bits 4:2 select sample rate, doubling per code.
// R7: Sample rate code resets to 100.
// R8: Filter bit enables PWM output filtering.
// R9: Start temperature is code times 4 degrees.
// R10: Local start temperature resets to 32 degrees.
// R11: Remote start temperature resets to 48 degrees.
// R12: Span codes give 5 to 80 degrees.
// R13: Each window drives its own sensor channel.
// R14: Enable bit lets own override force full speed.
// R15: Enable cleared: own override does not force.
// R16: External override ignores the enable bit.
// R17: Revision nibble read-only, bits 6:4 zero.
// R18: External override pin low forces full speed.
// R19: Spin-up drives full duty, default 2 s.
// R20: Auto duty rises from minimum across span.
module fcc_fan_control_regs
  import fcc_pkg::*;
#(
  parameter longint SPIN_UNIT_CYCLES = FCC_SPIN_UNIT_CYCLES,
  parameter longint UPD_BASE_CYCLES = FCC_UPD_BASE_CYCLES,
  parameter longint RAMP_STEP_CYCLES = FCC_RAMP_STEP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] local_temp,
  input wire logic [7:0] remote_temp,
  input wire logic therm_request,
  input wire logic therm_in,
  output logic therm_out,
  output logic therm_oe_n,
  output logic pwm_out
);

  // Register state.
  logic [3:0] speed_ff;
  fcc_filter_type filter_ff;
  fcc_window_type local_win_ff, remote_win_ff;
  logic ovr_en_ff;
  fcc_ctrl_type ctrl_ff;

  // Bus state.
  logic aw_held_ff, w_held_ff, wlane_ff, rd_hit, wr_fire, wr_hit;
  logic [7:0] aw_idx_ff, wdata_ff, ar_idx;
  logic [31:0] nxt_rdata;

  // Fan state.
  logic therm_meta_ff, therm_sync_ff, pwm_raw_ff, pwm_filt_ff;
  logic ext_low, force_full, upd_tick, ramp_tick, pwm_tick;
  logic [1:0] req_dly_ff;
  logic [7:0] local_samp_ff, remote_samp_ff, duty_ff, pwm_pre_ff, pwm_cnt_ff, filt_cnt_ff;
  logic [7:0] target, min_duty, local_duty, remote_duty, step;
  logic [63:0] upd_cnt_ff, ramp_cnt_ff, unit_cnt_ff;
  logic [5:0] spin_units_ff;
  fcc_run_type run_ff;

  // Duty for one channel: minimum at the start temperature, full at start plus span.
  function automatic logic [7:0] fcc_auto_duty(input logic [7:0] temp, input fcc_window_type win,
                                               input logic [7:0] base);
    logic [7:0] start, excess, span;
    logic [15:0] prod;
    start = {1'b0, win.start_code, 2'b00}; // R9
    excess = temp - start;
    case (win.span_code) // R12
      3'h0: span = 8'h05;
      3'h1: span = 8'h0a;
      3'h2: span = 8'h14;
      3'h3: span = 8'h28;
      default: span = 8'h50;
    endcase
    prod = 16'(FCC_DUTY_FULL - base) * 16'(excess);
    if (temp <= start) begin
      fcc_auto_duty = base; // R2
    end else if (excess >= span) begin
      fcc_auto_duty = FCC_DUTY_FULL; // R20
    end else begin
      fcc_auto_duty = base + 8'(prod / 16'(span)); // R20
    end
  endfunction

  // Spin-up length in 200 ms units for each time code.
  function automatic logic [5:0] fcc_spin_units(input logic [2:0] code);
    case (code)
      3'h0: fcc_spin_units = 6'h01;
      3'h1: fcc_spin_units = 6'h02;
      3'h2: fcc_spin_units = 6'h03;
      3'h3: fcc_spin_units = 6'h04;
      3'h4: fcc_spin_units = 6'h05;
      3'h5: fcc_spin_units = 6'h0a;
      3'h6: fcc_spin_units = 6'h14;
      default: fcc_spin_units = 6'h28;
    endcase
  endfunction

  // Write channel handshakes; each side is taken once and held until the pair completes.
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
  assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_hit = aw_idx_ff inside {FCC_IDX_SPEED, FCC_IDX_FILTER, FCC_IDX_LOCAL_WIN, FCC_IDX_REMOTE_WIN,
                                    FCC_IDX_OVERRIDE, FCC_IDX_CTRL, FCC_IDX_STATUS};

  // Address and data capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_idx_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wlane_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_idx_ff <= (s_axi_awaddr[31:10] == 22'h000000) ? s_axi_awaddr[9:2] : 8'hff;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata[7:0];
        wlane_ff <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response; unmapped indices answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= FCC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? FCC_RESP_OKAY : FCC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Writable registers; only byte lane 0 carries register bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_ff <= FCC_RST_SPEED; // R3
      filter_ff <= FCC_RST_FILTER; // R7
      local_win_ff <= FCC_RST_LOCAL_WIN; // R10
      remote_win_ff <= FCC_RST_REMOTE_WIN; // R11
      ovr_en_ff <= FCC_RST_OVR_EN; // R14
      ctrl_ff <= {FCC_RST_SPIN_CODE, FCC_RST_AUTO}; // R19
    end else if (wr_fire && wlane_ff) begin
      case (aw_idx_ff)
        FCC_IDX_SPEED: speed_ff <= wdata_ff[3:0];
        FCC_IDX_FILTER: filter_ff <= wdata_ff;
        FCC_IDX_LOCAL_WIN: local_win_ff <= wdata_ff;
        FCC_IDX_REMOTE_WIN: remote_win_ff <= wdata_ff;
        FCC_IDX_OVERRIDE: ovr_en_ff <= wdata_ff[7];
        FCC_IDX_CTRL: ctrl_ff <= wdata_ff[3:0];
        default: ;
      endcase
    end
  end

  // Read decode.
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_idx = s_axi_araddr[9:2];
  always_comb begin
    nxt_rdata = 32'h00000000;
    rd_hit = (s_axi_araddr[31:10] == 22'h000000);
    case (ar_idx)
      FCC_IDX_SPEED: nxt_rdata[3:0] = speed_ff;
      FCC_IDX_FILTER: nxt_rdata[7:0] = filter_ff;
      FCC_IDX_LOCAL_WIN: nxt_rdata[7:0] = local_win_ff;
      FCC_IDX_REMOTE_WIN: nxt_rdata[7:0] = remote_win_ff;
      FCC_IDX_OVERRIDE: nxt_rdata[7:0] = {ovr_en_ff, 3'h0, FCC_REVISION}; // R17
      FCC_IDX_CTRL: nxt_rdata[3:0] = ctrl_ff;
      FCC_IDX_STATUS: nxt_rdata[10:0] = {ext_low, force_full, run_ff == FCC_RUN_SPIN, duty_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read answer, one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= FCC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= nxt_rdata;
      s_axi_rresp <= rd_hit ? FCC_RESP_OKAY : FCC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Override pin synchroniser; our request is delayed alongside so that our own release is not seen as an outside pull.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      therm_meta_ff <= 1'b1;
      therm_sync_ff <= 1'b1;
      req_dly_ff <= 2'h0;
    end else begin
      therm_meta_ff <= therm_in;
      therm_sync_ff <= therm_meta_ff;
      req_dly_ff <= {req_dly_ff[0], therm_request};
    end
  end

  // The pin is pulled low by our own request; low while we do not drive means an outside agent.
  assign therm_out = 1'b0;
  assign therm_oe_n = !therm_request;
  assign ext_low = !therm_sync_ff && !therm_request && (req_dly_ff == 2'h0); // R18
  assign force_full = ext_low || (therm_request && ovr_en_ff); // R14 R15 R16

  // Temperature update interval: 16 s halved for each code step.
  assign upd_tick = (upd_cnt_ff >= ((UPD_BASE_CYCLES >> filter_ff.sample_code) - 64'd1)); // R6
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upd_cnt_ff <= 64'd0;
      local_samp_ff <= 8'h00;
      remote_samp_ff <= 8'h00;
    end else if (upd_tick) begin
      upd_cnt_ff <= 64'd0;
      local_samp_ff <= local_temp;
      remote_samp_ff <= remote_temp;
    end else begin
      upd_cnt_ff <= upd_cnt_ff + 64'd1;
    end
  end

  // Target duty: full when forced, else manual nibble, or the larger of the two channel curves in auto mode.
  assign min_duty = 8'(speed_ff * FCC_DUTY_PER_NIBBLE);
  assign local_duty = fcc_auto_duty(local_samp_ff, local_win_ff, min_duty); // R13
  assign remote_duty = fcc_auto_duty(remote_samp_ff, remote_win_ff, min_duty); // R13
  always_comb begin
    if (force_full) begin
      target = FCC_DUTY_FULL;
    end else if (ctrl_ff.auto_en) begin
      target = (local_duty > remote_duty) ? local_duty : remote_duty; // R2
    end else begin
      target = min_duty; // R1
    end
  end

  // Ramp tick and step size.
  assign ramp_tick = (ramp_cnt_ff >= (RAMP_STEP_CYCLES - 64'd1));
  assign step = 8'h01 << filter_ff.ramp_code; // R5
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp_cnt_ff <= 64'd0;
    end else if (ramp_tick) begin
      ramp_cnt_ff <= 64'd0;
    end else begin
      ramp_cnt_ff <= ramp_cnt_ff + 64'd1;
    end
  end

  // Run sequencer: a stopped fan starting up is kicked at full duty first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ff <= FCC_RUN_IDLE;
      unit_cnt_ff <= 64'd0;
      spin_units_ff <= 6'h00;
    end else begin
      case (run_ff)
        FCC_RUN_IDLE: begin
          if (target != FCC_DUTY_ZERO) begin
            if (filter_ff.spin_disable) begin
              run_ff <= FCC_RUN_NORMAL; // R4
            end else begin
              run_ff <= FCC_RUN_SPIN; // R19
              unit_cnt_ff <= 64'd0;
              spin_units_ff <= fcc_spin_units(ctrl_ff.spin_code);
            end
          end
        end
        FCC_RUN_SPIN: begin
          if (unit_cnt_ff >= (SPIN_UNIT_CYCLES - 64'd1)) begin
            unit_cnt_ff <= 64'd0;
            spin_units_ff <= spin_units_ff - 6'h01;
            if (spin_units_ff == 6'h01) begin
              run_ff <= FCC_RUN_NORMAL;
            end
          end else begin
            unit_cnt_ff <= unit_cnt_ff + 64'd1;
          end
        end
        FCC_RUN_NORMAL: begin
          if (target == FCC_DUTY_ZERO && duty_ff == FCC_DUTY_ZERO) begin
            run_ff <= FCC_RUN_IDLE;
          end
        end
        default: run_ff <= FCC_RUN_IDLE;
      endcase
    end
  end

  // Output duty: full during spin-up or while forced to full speed, otherwise stepped toward the target at the ramp rate.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_ff <= FCC_DUTY_ZERO;
    end else if (run_ff == FCC_RUN_SPIN || force_full) begin
      duty_ff <= FCC_DUTY_FULL; // R19
    end else if (run_ff == FCC_RUN_NORMAL && ramp_tick) begin
      if (duty_ff < target) begin
        duty_ff <= ((target - duty_ff) > step) ? duty_ff + step : target; // R5
      end else if (duty_ff > target) begin
        duty_ff <= ((duty_ff - target) > step) ? duty_ff - step : target; // R5
      end
    end
  end

  // PWM generator; 255 slots per period so full duty stays high.
  assign pwm_tick = (pwm_pre_ff == (FCC_PWM_PRESCALE - 8'h01));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_pre_ff <= 8'h00;
      pwm_cnt_ff <= 8'h00;
      pwm_raw_ff <= 1'b0;
    end else begin
      pwm_pre_ff <= pwm_tick ? 8'h00 : pwm_pre_ff + 8'h01;
      if (pwm_tick) begin
        pwm_cnt_ff <= (pwm_cnt_ff == 8'hfe) ? 8'h00 : pwm_cnt_ff + 8'h01;
      end
      pwm_raw_ff <= (pwm_cnt_ff < duty_ff);
    end
  end

  // Output filter: a new level must hold for a set time before it reaches the pin.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_filt_ff <= 1'b0;
      filt_cnt_ff <= 8'h00;
    end else if (pwm_raw_ff == pwm_filt_ff) begin
      filt_cnt_ff <= 8'h00;
    end else if (filt_cnt_ff >= (FCC_FILT_CYCLES - 8'h01)) begin
      pwm_filt_ff <= pwm_raw_ff;
      filt_cnt_ff <= 8'h00;
    end else begin
      filt_cnt_ff <= filt_cnt_ff + 8'h01;
    end
  end

  assign pwm_out = filter_ff.filter_en ? pwm_filt_ff : pwm_raw_ff; // R8

endmodule

// [logic/fcc_pkg.sv]
package fcc_pkg;

  // Clock rate and the time units that long counts are built from.
  localparam longint FCC_CLK_HZ = 64'd250_000_000;
  localparam longint FCC_SPIN_UNIT_MS = 64'd200;
  localparam longint FCC_SPIN_UNIT_CYCLES = FCC_SPIN_UNIT_MS * FCC_CLK_HZ / 64'd1000;
  localparam longint FCC_UPD_BASE_S = 64'd16;
  localparam longint FCC_UPD_BASE_CYCLES = FCC_UPD_BASE_S * FCC_CLK_HZ;
  localparam longint FCC_RAMP_STEP_MS = 64'd10;
  localparam longint FCC_RAMP_STEP_CYCLES = FCC_RAMP_STEP_MS * FCC_CLK_HZ / 64'd1000;
  localparam logic [7:0] FCC_PWM_PRESCALE = 8'h04;
  localparam logic [7:0] FCC_FILT_CYCLES = 8'h10;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] FCC_IDX_SPEED = 8'h22;
  localparam logic [7:0] FCC_IDX_FILTER = 8'h23;
  localparam logic [7:0] FCC_IDX_LOCAL_WIN = 8'h24;
  localparam logic [7:0] FCC_IDX_REMOTE_WIN = 8'h25;
  localparam logic [7:0] FCC_IDX_OVERRIDE = 8'h3f;
  localparam logic [7:0] FCC_IDX_CTRL = 8'h40;
  localparam logic [7:0] FCC_IDX_STATUS = 8'h41;

  // Reset values.
  localparam logic [3:0] FCC_RST_SPEED = 4'h5;
  localparam logic [7:0] FCC_RST_FILTER = 8'h50;
  localparam logic [7:0] FCC_RST_LOCAL_WIN = 8'h41;
  localparam logic [7:0] FCC_RST_REMOTE_WIN = 8'h61;
  localparam logic FCC_RST_OVR_EN = 1'b1;
  localparam logic [2:0] FCC_RST_SPIN_CODE = 3'h5;
  localparam logic FCC_RST_AUTO = 1'b0;

  // Revision nibble; the value is arbitrary.
  localparam logic [3:0] FCC_REVISION = 4'h1;

  // Duty levels on the 0 to 255 scale.
  localparam logic [7:0] FCC_DUTY_FULL = 8'hff;
  localparam logic [7:0] FCC_DUTY_PER_NIBBLE = 8'h11;
  localparam logic [7:0] FCC_DUTY_ZERO = 8'h00;

  // AXI responses.
  localparam logic [1:0] FCC_RESP_OKAY = 2'b00;
  localparam logic [1:0] FCC_RESP_SLVERR = 2'b10;

  // Fan filter register layout.
  typedef struct packed {
    logic spin_disable;
    logic [1:0] ramp_code;
    logic [2:0] sample_code;
    logic spare;
    logic filter_en;
  } fcc_filter_type;

  // Start temperature and span of one automatic channel.
  typedef struct packed {
    logic [4:0] start_code;
    logic [2:0] span_code;
  } fcc_window_type;

  // Own control register layout.
  typedef struct packed {
    logic [2:0] spin_code;
    logic auto_en;
  } fcc_ctrl_type;

  typedef enum {
    FCC_RUN_IDLE,
    FCC_RUN_SPIN,
    FCC_RUN_NORMAL
  } fcc_run_type;

endpackage

// [tb/fcc_fan_model.sv]
`timescale 1ns/100ps
// Cooling fan stand-in that measures PWM high time over each full PWM period.
module fcc_fan_model #(
  parameter int PERIOD = 1020
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pwm_out,
  output logic [15:0] high_cnt_ff
);
  logic [15:0] win_ff;
  logic [15:0] acc_ff;

  // Accumulate high cycles and publish the total when a window closes.
  always_ff @(posedge aclk) begin
    if (!aresetn || win_ff == 16'(PERIOD - 1)) begin
      win_ff <= 16'h0;
      acc_ff <= 16'h0;
      high_cnt_ff <= aresetn ? acc_ff + {15'h0, pwm_out} : 16'h0;
    end else begin
      win_ff <= win_ff + 16'h1;
      acc_ff <= acc_ff + {15'h0, pwm_out};
    end
  end
endmodule

// [tb/fcc_fan_control_regs_chk.sv]
`timescale 1ns/100ps
module fcc_fan_control_regs_chk
  import fcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic therm_request,
  input wire logic therm_in,
  input wire logic therm_out,
  input wire logic therm_oe_n,
  input wire logic pwm_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] rd_addr_ff;
  logic [5:0] ext_cnt_ff;
  logic rd_mapped;

  // Remember the address of the read under way.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_ff <= s_axi_araddr;
    end
  end
  // Count how long the pin has been held low by someone else, saturating.
  always_ff @(posedge aclk) begin
    if (!aresetn || therm_in || therm_request) begin
      ext_cnt_ff <= 6'h0;
    end else if (ext_cnt_ff != 6'h28) begin
      ext_cnt_ff <= ext_cnt_ff + 6'h1;
    end
  end
  // Decide whether the captured address hits a register.
  assign rd_mapped = (rd_addr_ff[31:10] == 22'h0) && (rd_addr_ff[9:2] inside
    {FCC_IDX_SPEED, FCC_IDX_FILTER, FCC_IDX_LOCAL_WIN, FCC_IDX_REMOTE_WIN, FCC_IDX_OVERRIDE, FCC_IDX_CTRL, FCC_IDX_STATUS});

  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_waiting;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  property p_rd_answer;
    s_ar_taken |=> s_axi_rvalid;
  endproperty
  property p_rd_hold;
    s_r_waiting |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_wr_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_rd_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_rd_unmapped;
    s_axi_rvalid && !rd_mapped |-> s_axi_rresp == FCC_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  property p_rev;
    s_axi_rvalid && rd_addr_ff == {22'h0, FCC_IDX_OVERRIDE, 2'h0} |-> s_axi_rdata[6:0] == {3'h0, FCC_REVISION};
  endproperty
  property p_pin;
    therm_oe_n == !therm_request && therm_out == 1'h0;
  endproperty
  property p_ext_full;
    ext_cnt_ff == 6'h28 |-> pwm_out;
  endproperty

  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  a_rd_hold: assert property (p_rd_hold) else $error("read answer not held");
  a_wr_hold: assert property (p_wr_hold) else $error("write answer not held");
  a_wr_block: assert property (p_wr_block) else $error("write taken while answer pending");
  a_rd_block: assert property (p_rd_block) else $error("read taken while answer pending");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read answered wrongly");
  a_rev: assert property (p_rev) else $error("revision field wrong");
  a_pin: assert property (p_pin) else $error("override pin drive wrong");
  a_ext_full: assert property (p_ext_full) else $error("external override not full speed");
endmodule

bind fcc_fan_control_regs fcc_fan_control_regs_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .therm_request(therm_request), .therm_in(therm_in), .therm_out(therm_out),
  .therm_oe_n(therm_oe_n), .pwm_out(pwm_out));

// [tb/fcc_fan_control_regs_tb_top.sv]
`timescale 1ns/100ps
module fcc_fan_control_regs_tb_top
  import fcc_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic [7:0] local_temp = 8'h0, remote_temp = 8'h0;
  logic therm_request = 1'h0, ext_low = 1'h0, therm_in, therm_out, therm_oe_n, pwm_out, slow_ready = 1'h0;
  logic [31:0] rd_data;
  logic [15:0] fan_high;
  int n_mismatch = 0, num_checks = 0, cycles = 0;

  // The override pin has a pull-up; either party may pull it low.
  assign therm_in = !therm_oe_n ? therm_out : !ext_low;

  fcc_fan_control_regs #(.SPIN_UNIT_CYCLES(20), .UPD_BASE_CYCLES(256), .RAMP_STEP_CYCLES(4)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .local_temp(local_temp), .remote_temp(remote_temp), .therm_request(therm_request),
    .therm_in(therm_in), .therm_out(therm_out), .therm_oe_n(therm_oe_n), .pwm_out(pwm_out));
  fcc_fan_model #(.PERIOD(1020)) u_fan (.aclk(aclk), .aresetn(aresetn), .pwm_out(pwm_out), .high_cnt_ff(fan_high));

  // Clock at 250 MHz and a hang limit far above the expected run length.
  always #2 aclk = !aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t response %h expected %h", $time, got, exp);
    end
  endtask
  // Write one register word; ready is looked at on the falling edge before the sampling edge.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a = 1'h0;
    logic w = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= !slow_ready;
    while (!(a && w)) begin
      @(negedge aclk);
      a = a || s_axi_awready;
      w = w || s_axi_wready;
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
    chk_resp(s_axi_bresp, er);
    if (slow_ready) begin
      repeat (3) @(posedge aclk);
      s_axi_bready <= 1'h1;
    end
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask
  // Read one register word into rd_data and rd_resp.
  task automatic rd(input logic [7:0] idx);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= !slow_ready;
    do @(negedge aclk); while (s_axi_arready !== 1'h1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    if (slow_ready) begin
      repeat (3) @(posedge aclk);
      s_axi_rready <= 1'h1;
    end
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    rd(idx);
    chk32(rd_data, exp);
    chk_resp(rd_resp, er);
  endtask
  task automatic wait_duty(input int n);
    repeat (n) @(posedge aclk);
    rd(FCC_IDX_STATUS);
  endtask

  // Spin-up at full duty straight after reset, then the default speed nibble on the fan.
  task automatic t_spin_default();
    wait_duty(2);
    chk32({23'h0, rd_data[8:0]}, 32'h1ff);
    wait_duty(1100);
    chk32({23'h0, rd_data[8:0]}, 32'h55);
    repeat (2100) @(posedge aclk);
    chk32({16'h0, fan_high}, 32'h154);
  endtask
  // Reset values, read-write fields, read-only fields and unmapped places.
  task automatic t_regs();
    rd_chk(FCC_IDX_SPEED, 32'h05, FCC_RESP_OKAY);
    rd_chk(FCC_IDX_FILTER, 32'h50, FCC_RESP_OKAY);
    rd_chk(FCC_IDX_LOCAL_WIN, 32'h41, FCC_RESP_OKAY);
    rd_chk(FCC_IDX_REMOTE_WIN, 32'h61, FCC_RESP_OKAY);
    rd_chk(FCC_IDX_OVERRIDE, {24'h0, 4'h8, FCC_REVISION}, FCC_RESP_OKAY);
    slow_ready = 1'h1;
    wr(FCC_IDX_FILTER, 8'hff, FCC_RESP_OKAY);
    rd_chk(FCC_IDX_FILTER, 32'hff, FCC_RESP_OKAY);
    slow_ready = 1'h0;
    wr(FCC_IDX_LOCAL_WIN, 8'ha3, FCC_RESP_OKAY);
    rd_chk(FCC_IDX_LOCAL_WIN, 32'ha3, FCC_RESP_OKAY);
    wr(FCC_IDX_REMOTE_WIN, 8'hfc, FCC_RESP_OKAY);
    rd_chk(FCC_IDX_REMOTE_WIN, 32'hfc, FCC_RESP_OKAY);
    wr(FCC_IDX_OVERRIDE, 8'h7f, FCC_RESP_OKAY);
    rd_chk(FCC_IDX_OVERRIDE, {28'h0, FCC_REVISION}, FCC_RESP_OKAY);
    wr(8'h30, 8'h12, FCC_RESP_SLVERR);
    rd_chk(8'h30, 32'h0, FCC_RESP_SLVERR);
    wr(FCC_IDX_OVERRIDE, 8'h80, FCC_RESP_OKAY);
  endtask
  // Each ramp code, with spin-up disabled so the climb starts from zero.
  task automatic t_ramp();
    int step;
    for (int k = 0; k < 4; k++) begin
      step = 1 << k;
      wr(FCC_IDX_FILTER, 8'hf0, FCC_RESP_OKAY);
      wr(FCC_IDX_SPEED, 8'h00, FCC_RESP_OKAY);
      repeat (200) @(posedge aclk);
      wr(FCC_IDX_FILTER, 8'h90 | 8'(k << 5), FCC_RESP_OKAY);
      wr(FCC_IDX_SPEED, 8'h0f, FCC_RESP_OKAY);
      wait_duty(510 / step);
      chk32({31'h0, rd_data[7:0] < 8'hff && rd_data[7:0] > 8'h40}, 32'h1);
      wait_duty(510 / step + 40);
      chk32({24'h0, rd_data[7:0]}, 32'hff);
    end
  endtask
  // Own override with the enable set and cleared, then an external pull.
  task automatic t_override();
    wr(FCC_IDX_FILTER, 8'hf0, FCC_RESP_OKAY);
    wr(FCC_IDX_SPEED, 8'h00, FCC_RESP_OKAY);
    repeat (200) @(posedge aclk);
    therm_request <= 1'h1;
    wait_duty(10);
    chk32({23'h0, rd_data[9], rd_data[7:0]}, 32'h1ff);
    therm_request <= 1'h0;
    wr(FCC_IDX_OVERRIDE, 8'h00, FCC_RESP_OKAY);
    repeat (200) @(posedge aclk);
    therm_request <= 1'h1;
    wait_duty(20);
    chk32({23'h0, rd_data[9], rd_data[7:0]}, 32'h0);
    therm_request <= 1'h0;
    wait_duty(10);
    chk32({23'h0, rd_data[10], rd_data[7:0]}, 32'h0);
    ext_low <= 1'h1;
    wait_duty(60);
    chk32({23'h0, rd_data[10], rd_data[7:0]}, 32'h1ff);
    ext_low <= 1'h0;
    wr(FCC_IDX_OVERRIDE, 8'h80, FCC_RESP_OKAY);
    repeat (200) @(posedge aclk);
  endtask
  // Automatic control within the span on each channel, then at the minimum and above the span on the local one.
  task automatic t_auto();
    wr(FCC_IDX_LOCAL_WIN, 8'h41, FCC_RESP_OKAY);
    wr(FCC_IDX_REMOTE_WIN, 8'h61, FCC_RESP_OKAY);
    local_temp <= 8'h25;
    wr(FCC_IDX_CTRL, 8'h0b, FCC_RESP_OKAY);
    wait_duty(300);
    chk32({24'h0, rd_data[7:0]}, 32'h7f);
    local_temp <= 8'h00;
    remote_temp <= 8'h3c;
    wr(FCC_IDX_REMOTE_WIN, 8'h62, FCC_RESP_OKAY);
    wait_duty(300);
    chk32({24'h0, rd_data[7:0]}, 32'h99);
    remote_temp <= 8'h00;
    wr(FCC_IDX_SPEED, 8'h03, FCC_RESP_OKAY);
    wait_duty(300);
    chk32({24'h0, rd_data[7:0]}, 32'h33);
    local_temp <= 8'hc8;
    wait_duty(300);
    chk32({24'h0, rd_data[7:0]}, 32'hff);
  endtask

  // Main sequence.
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_spin_default();
    t_regs();
    t_ramp();
    t_override();
    t_auto();
    print_verdict();
  end
endmodule
